// File: sat_bus_if.sv
// Purpose: Bus interface between the shared backplane and local CPU/RAM.
// Assumes: Bus inputs are synchronous to clk; local CPU has hold/ack.
// Notes:   Master owns all sequencing; the card is a passive slave.
// Notes on behaviour
// (RULE1) Card answers only the select line matching its jumpered number.
// (RULE2) Unselected card keeps all its bus drivers off; bus_irq_oe here follows irq_q whatever the select.
// (RULE3) Active select asserts the local CPU hold request.
// (RULE4) While held only master cycles reach local memory.
// (RULE5) Master-to-card writes accepted only with phantom asserted.
// (RULE6) Card drives read data only with phantom asserted.
// (RULE7) Card drives only interrupt, wait and read data toward the bus.
// (RULE8) Firmware can raise the bus interrupt request.
// (RULE9) Master polls mailboxes after an interrupt and writes replies.
// (RULE10) Mailbox is a scratch RAM region the master reaches while held.
// (RULE11) Alternative system polls a data window instead of interrupts.
// (RULE12) Master sequences every transfer; card starts none.
// (RULE13) Block moves run at full processor speed, no extra cycles.
// (RULE14) Unselected card isolates bus so local side runs alone.
// (RULE15) DMA drivers enabled only by the CPU hold acknowledge.
// (RULE16) Bus has sixteen address lines and split eight-bit data paths.
// (RULE17) Local serial port decode ignores master I/O cycles.
// (RULE18) Wait is asserted on master memory cycles until acknowledge.
// (RULE19) Deselect releases hold and drivers; CPU resumes.
`timescale 1ns/10ps
`include "sat_cfg.svh"
module sat_bus_if #(
  parameter int N = `SAT_NUM_SLOTS
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic [N-1:0]         select_lines,
  input  wire logic [`SAT_ID_W-1:0] id_jumper,
  input  wire sat_pkg::sbus_req_t   sbus,
  output sat_pkg::data_t            bus_din,
  output logic                      bus_din_oe,
  output logic                      bus_wait,
  output logic                      bus_irq,
  output logic                      bus_irq_oe,
  input  wire logic                 fw_irq_set,
  input  wire logic                 fw_irq_clr,
  output logic                      cpu_hold_request,
  input  wire logic                 cpu_hold_ack,
  input  wire logic                 cpu_io_cycle,
  input  wire sat_pkg::addr_t       cpu_io_addr,
  output logic                      usart_sel,
  output sat_pkg::mem_req_t         mem,
  input  wire sat_pkg::data_t       mem_rdata,
  output logic                      mbox_access
);
  import sat_pkg::*;

  logic        satellite_select_line;
  hold_state_t state_q;
  hold_state_t state_d;
  logic        irq_q;
  logic        granted;

  // ******************************************************************
  // Select decode
  // ******************************************************************
  sat_select #(.N(N)) u_sel (
    .clk          (clk),
    .nrst         (nrst),
    .select_lines (select_lines),
    .id_jumper    (id_jumper),
    .selected     (satellite_select_line)
  );

  // ******************************************************************
  // Hold sequencing
  // ******************************************************************
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      st_free: begin
        if (satellite_select_line) state_d = st_hold; // [RULE3]
      end
      st_hold: begin
        if (!satellite_select_line) state_d = st_free; // [RULE19]
        else if (cpu_hold_ack) state_d = st_dma;
      end
      st_dma: begin
        if (!satellite_select_line) state_d = st_free; // [RULE19]
        else if (!cpu_hold_ack) state_d = st_hold;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= st_free;
    end else begin
      state_q <= state_d;
    end
  end

  assign cpu_hold_request = (state_q != st_free); // [RULE3]
  // Drivers need both our state and the live acknowledge, so the two CPUs never overlap.
  assign granted = (state_q == st_dma) && cpu_hold_ack; // [RULE15]

  // ******************************************************************
  // Memory path toward local RAM
  // ******************************************************************
  always_comb begin
    mem.dma_en = granted; // [RULE4]
    mem.addr   = sbus.addr; // [RULE16]
    mem.wdata  = sbus.dout;
    mem.mem_wr = granted && sbus.mem_wr && sbus.phantom && !sbus.io_cycle; // [RULE5]
    mem.mem_rd = granted && sbus.mem_rd && sbus.phantom && !sbus.io_cycle; // [RULE6]
  end

  assign mbox_access = (mem.mem_rd || mem.mem_wr)
                    && (sbus.addr >= `SAT_MBOX_BASE)
                    && (sbus.addr <= `SAT_MBOX_LAST); // [RULE10]

  // ******************************************************************
  // Read data toward the master
  // ******************************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bus_din <= '0;
    end else if (mem.mem_rd) begin
      bus_din <= mem_rdata; // [RULE6]
    end
  end

  // Read data sits on the bus only while selected and phantom says so.
  assign bus_din_oe = mem.mem_rd; // [RULE2] [RULE14]

  // ******************************************************************
  // Wait and interrupt toward the master
  // ******************************************************************
  // Wait stretches a phantom memory cycle until the CPU lets go; no
  // extra cycles are inserted once held, keeping block moves full speed.
  assign bus_wait = satellite_select_line && !granted && sbus.phantom
                 && (sbus.mem_rd || sbus.mem_wr); // [RULE18] [RULE13] [RULE7]

  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_q <= 1'b0;
    end else if (fw_irq_set) begin
      irq_q <= 1'b1; // [RULE8]
    end else if (fw_irq_clr) begin
      irq_q <= 1'b0;
    end
  end

  assign bus_irq    = irq_q;
  assign bus_irq_oe = irq_q; // [RULE7]

  // ******************************************************************
  // Local serial port decode
  // ******************************************************************
  assign usart_sel = cpu_io_cycle && !cpu_hold_request
                  && (cpu_io_addr[7:0] == `SAT_USART_PORT); // [RULE17]

  // ******************************************************************
  // Checks
  // ******************************************************************
  property p_iso;
    @(posedge clk) disable iff (!nrst)
    !satellite_select_line |-> ##1 (!bus_din_oe && !mem.dma_en);
  endproperty
  a_iso: assert property (p_iso) // [RULE2]
    else $error("drivers on while unselected");

  property p_hold;
    @(posedge clk) disable iff (!nrst)
    $rose(satellite_select_line) |=> cpu_hold_request;
  endproperty
  a_hold: assert property (p_hold) // [RULE3]
    else $error("hold not requested");

  property p_mem_only_held;
    @(posedge clk) disable iff (!nrst)
    (mem.mem_rd || mem.mem_wr) |-> (cpu_hold_ack && cpu_hold_request);
  endproperty
  a_mem_only_held: assert property (p_mem_only_held) // [RULE4]
    else $error("memory cycle without hold");

  property p_wr_phantom;
    @(posedge clk) disable iff (!nrst)
    mem.mem_wr |-> sbus.phantom;
  endproperty
  a_wr_phantom: assert property (p_wr_phantom) // [RULE5]
    else $error("write accepted without phantom");

  property p_rd_phantom;
    @(posedge clk) disable iff (!nrst)
    !sbus.phantom |-> !bus_din_oe;
  endproperty
  a_rd_phantom: assert property (p_rd_phantom) // [RULE6]
    else $error("read driven without phantom");

  property p_irq;
    @(posedge clk) disable iff (!nrst)
    fw_irq_set |=> bus_irq;
  endproperty
  a_irq: assert property (p_irq) // [RULE8]
    else $error("irq not raised");

  property p_wait;
    @(posedge clk) disable iff (!nrst)
    (satellite_select_line && !cpu_hold_ack && sbus.phantom && sbus.mem_wr)
      |-> bus_wait;
  endproperty
  a_wait: assert property (p_wait) // [RULE18]
    else $error("no wait before acknowledge");

  property p_release;
    @(posedge clk) disable iff (!nrst)
    $fell(satellite_select_line) |=> !cpu_hold_request;
  endproperty
  a_release: assert property (p_release) // [RULE19]
    else $error("hold kept after deselect");

  property p_usart;
    @(posedge clk) disable iff (!nrst)
    cpu_hold_request |-> !usart_sel;
  endproperty
  a_usart: assert property (p_usart) // [RULE17]
    else $error("serial port seen while held");

  property p_dma_ack;
    @(posedge clk) disable iff (!nrst)
    mem.dma_en |-> (cpu_hold_ack && cpu_hold_request);
  endproperty
  a_dma_ack: assert property (p_dma_ack) // [RULE15]
    else $error("drivers on without acknowledge");

  property p_no_wait_granted;
    @(posedge clk) disable iff (!nrst)
    granted |-> !bus_wait;
  endproperty
  a_no_wait_granted: assert property (p_no_wait_granted) // [RULE13]
    else $error("wait while granted");
endmodule : sat_bus_if

// File: sat_cfg.svh
// Purpose: Constants for the satellite bus interface.
// Assumes: One 10 MHz clock, synchronous active-low reset.
// Notes:   Included by the package and the design modules.
`ifndef SAT_CFG_SVH
`define SAT_CFG_SVH
`define SAT_NUM_SLOTS   8
`define SAT_ADDR_W      16
`define SAT_DATA_W      8
`define SAT_ID_W        3
`define SAT_USART_PORT  8'h40
`define SAT_MBOX_BASE   16'hff00
`define SAT_MBOX_LAST   16'hffff
`endif

// File: sat_pkg.sv
// Purpose: Types shared by the satellite bus interface files.
// Assumes: sat_cfg.svh is on the include path.
// Notes:   Bus request and local memory request groups travel as packed structs.
`include "sat_cfg.svh"
package sat_pkg;
  typedef logic [`SAT_ADDR_W-1:0] addr_t;
  typedef logic [`SAT_DATA_W-1:0] data_t;
  typedef struct packed {
    logic  mem_rd;
    logic  mem_wr;
    logic  io_cycle;
    logic  phantom;
    addr_t addr;
    data_t dout;
  } sbus_req_t;
  typedef struct packed {
    logic  dma_en;
    logic  mem_rd;
    logic  mem_wr;
    addr_t addr;
    data_t wdata;
  } mem_req_t;
  typedef enum logic [1:0] {st_free, st_hold, st_dma} hold_state_t;
endpackage : sat_pkg

// File: sat_select.sv
// Purpose: Picks this card's select line from the shared bus lines.
// Assumes: Identity jumper is stable; sampled on every clock, reset or not.
// Notes:   Jumper value zero maps to select line index zero.
`timescale 1ns/10ps
`include "sat_cfg.svh"
module sat_select #(
  parameter int N = `SAT_NUM_SLOTS
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic [N-1:0]         select_lines,
  input  wire logic [`SAT_ID_W-1:0] id_jumper,
  output logic                      selected
);
  logic [`SAT_ID_W-1:0] id_q;
  logic [N-1:0]         hit;

  always_ff @(posedge clk) begin
    id_q <= id_jumper;
  end

  // One decoder line per slot; only the matching one passes.
  for (genvar i = 0; i < N; i++) begin : g_slot
    assign hit[i] = select_lines[i] && (int'(id_q) == i); // [RULE1]
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      selected <= 1'b0;
    end else begin
      selected <= |hit;
    end
  end

  property p_one_line;
    @(posedge clk) disable iff (!nrst)
    $rose(selected) |-> $past(select_lines[id_q]);
  endproperty
  a_one_line: assert property (p_one_line) // [RULE1]
    else $error("selected without own line");
endmodule : sat_select

// File: sat_master.sv
// Purpose: Behavioural master card on the shared bus.
// Assumes: Every step starts just after a rising clock edge.
// Notes:   Idle data lines show the inverse of the last byte.
`timescale 1ns/10ps
module sat_master (
  input  wire logic          clk,
  output logic [7:0]         select_lines,
  output sat_pkg::sbus_req_t sbus
);
  import sat_pkg::*;
  // ****
  // Master side stepping.
  // ****
  initial begin
    select_lines = 8'h00;
    sbus = '0;
  end
  task automatic sel(input logic [7:0] v);
    @(posedge clk) #1 select_lines = v;
  endtask : sel
  task automatic cyc(input logic rd, wr, io, ph, input addr_t a, input data_t d);
    @(posedge clk) #1;
    sbus = {rd, wr, io, ph, a, d};
  endtask : cyc
  task automatic idle();
    @(posedge clk) #1;
    sbus = {4'h0, sbus.addr, ~sbus.dout};
  endtask : idle
endmodule : sat_master

// File: tb_sat_bus_if.sv
// Purpose: Self-checking bench for the satellite bus interface.
// Assumes: The master model drives select lines and bus cycles.
// Notes:   Local CPU and firmware inputs are driven here.
`timescale 1ns/10ps
module tb_sat_bus_if;
  import sat_pkg::*;
  logic      clk = 1'b0, nrst = 1'b0, fw_set = 1'b0, fw_clr = 1'b0, ack = 1'b0, cio = 1'b0;
  logic      din_oe, wt, irq, irq_oe, hold, usel, mbox;
  logic [7:0] sl;
  logic [2:0] id = 3'h0;
  addr_t     cadr = '0;
  data_t     rdat = 8'h00;
  data_t     din;
  sbus_req_t sbus;
  mem_req_t  mem;
  int        n_mismatch = 0, cmp_count = 0;
  always #50 clk = ~clk;
  sat_master m_u (.clk(clk), .select_lines(sl), .sbus(sbus));
  sat_bus_if dut_u (.clk(clk), .nrst(nrst), .select_lines(sl), .id_jumper(id), .sbus(sbus),
    .bus_din(din), .bus_din_oe(din_oe), .bus_wait(wt), .bus_irq(irq), .bus_irq_oe(irq_oe),
    .fw_irq_set(fw_set), .fw_irq_clr(fw_clr), .cpu_hold_request(hold), .cpu_hold_ack(ack),
    .cpu_io_cycle(cio), .cpu_io_addr(cadr), .usart_sel(usel), .mem(mem), .mem_rdata(rdat),
    .mbox_access(mbox));
  // ****
  // Checking helpers.
  // ****
  task automatic end_sim();
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic ok, input string s);
    cmp_count++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("mismatch %0t %s", $time, s);
    end
  endtask : chk
  task automatic wait_on(input bit dma, input logic v, input string s);
    for (int n = 0; n < 8; n++) begin
      if ((dma ? mem.dma_en : hold) === v) return;
      @(posedge clk) #1;
    end
    chk(1'b0, s);
    end_sim();
  endtask : wait_on
  // ****
  // Scenarios.
  // ****
  task automatic t_select();
    for (int i = 0; i < 8; i++) begin
      id = 3'(i);
      m_u.sel(8'h01 << ((i + 1) % 8));
      repeat (3) @(posedge clk);
      m_u.cyc(1'b1, 1'b0, 1'b0, 1'b1, 16'h0010, 8'h00);
      #1 chk(hold === 1'b0 && din_oe === 1'b0 && wt === 1'b0,
        "foreign line");
      m_u.idle();
      m_u.sel(8'h01 << i);
      wait_on(0, 1'b1, "no hold");
      m_u.sel(8'h00);
      wait_on(0, 1'b0, "hold stuck");
    end
  endtask : t_select
  task automatic t_dma();
    id = 3'h2;
    cio = 1'b1;
    cadr = 16'h0040;
    rdat = 8'hc3;
    m_u.sel(8'h04);
    wait_on(0, 1'b1, "no hold");
    m_u.cyc(1'b0, 1'b1, 1'b0, 1'b1, 16'h1234, 8'ha5);
    #1 chk(wt === 1'b1 && mem.mem_wr === 1'b0 && mem.dma_en === 1'b0,
      "early write");
    m_u.idle();
    ack = 1'b1;
    wait_on(1, 1'b1, "no dma");
    m_u.cyc(1'b0, 1'b1, 1'b0, 1'b1, 16'h1234, 8'ha5);
    #1 chk(mem.mem_wr === 1'b1 && mem.addr === 16'h1234
      && mem.wdata === 8'ha5 && wt === 1'b0, "write");
    m_u.cyc(1'b0, 1'b1, 1'b0, 1'b0, 16'h1235, 8'h5a);
    #1 chk(mem.mem_wr === 1'b0, "write without phantom");
    m_u.cyc(1'b0, 1'b1, 1'b0, 1'b1, 16'hff00, 8'h3c);
    #1 chk(mbox === 1'b1, "mailbox");
    m_u.cyc(1'b1, 1'b0, 1'b0, 1'b1, 16'hfeff, 8'h00);
    #1 chk(mem.mem_rd === 1'b1 && mbox === 1'b0 && din_oe === 1'b1, "read");
    @(posedge clk) #2 chk(din === 8'hc3, "read data");
    m_u.cyc(1'b1, 1'b0, 1'b0, 1'b0, 16'h0100, 8'h00);
    #1 chk(din_oe === 1'b0 && mem.mem_rd === 1'b0, "read without phantom");
    m_u.cyc(1'b0, 1'b1, 1'b1, 1'b1, 16'h0040, 8'h00);
    #1 chk(usel === 1'b0 && mem.mem_wr === 1'b0, "master io");
    m_u.idle();
    m_u.sel(8'h00);
    wait_on(0, 1'b0, "hold stuck");
    chk(din_oe === 1'b0 && mem.dma_en === 1'b0, "drivers on");
    ack = 1'b0;
    #1 chk(usel === 1'b1, "local port");
    @(posedge clk) #1 cio = 1'b0;
  endtask : t_dma
  task automatic t_irq();
    fw_set = 1'b1;
    @(posedge clk) #1 fw_set = 1'b0;
    #1 chk(irq === 1'b1 && irq_oe === 1'b1, "irq set");
    @(posedge clk) #1 fw_clr = 1'b1;
    @(posedge clk) #1 fw_clr = 1'b0;
    #1 chk(irq === 1'b0 && irq_oe === 1'b0, "irq clear");
    @(posedge clk) #1 fw_set = 1'b1;
    fw_clr = 1'b1;
    @(posedge clk) #1 fw_set = 1'b0;
    fw_clr = 1'b0;
    #1 chk(irq === 1'b1, "set beats clear");
  endtask : t_irq
  task automatic t_poll();
    @(posedge clk) #1 id = 3'h5;
    rdat = 8'h81;
    m_u.sel(8'h20);
    wait_on(0, 1'b1, "poll hold");
    ack = 1'b1;
    wait_on(1, 1'b1, "poll dma");
    m_u.cyc(1'b1, 1'b0, 1'b0, 1'b1, 16'hff00, 8'h00);
    @(posedge clk) #2 chk(din === 8'h81 && mbox === 1'b1, "mailbox read");
    m_u.cyc(1'b0, 1'b1, 1'b0, 1'b1, 16'hff01, 8'h7e);
    #1 chk(mem.mem_wr === 1'b1 && mem.wdata === 8'h7e
      && mbox === 1'b1, "reply");
    for (int k = 0; k < 2; k++) begin
      repeat (4) @(posedge clk);
      m_u.cyc(1'b1, 1'b0, 1'b0, 1'b1, 16'hf800 + 16'(k), 8'h00);
      #1 chk(mem.mem_rd === 1'b1 && mbox === 1'b0, "window poll");
    end
    m_u.idle();
    m_u.sel(8'h00);
    wait_on(0, 1'b0, "poll release");
    ack = 1'b0;
  endtask : t_poll
  initial begin
    repeat (4) @(posedge clk);
    #1 nrst = 1'b1;
    t_select();
    t_dma();
    t_irq();
    t_poll();
    end_sim();
  end
endmodule : tb_sat_bus_if
